// *** src/ocp_pkg.sv ***
// Purpose: Constants for the lamp switch over-current and bulb cooling timing
// Assumes: 250 MHz clock, a 10 us time base tick derived in the top module
// Notes: Profile tables hold step durations in time base ticks (10 us each)
//
// What this block does
// [RULE1] Over-current speed code 00 slow (reset default), 01 fast, 10 medium, 11 very slow.
// [RULE2] Low-wattage bit 1 uses its own seven-step profile, slow 4.9..89.2 ms.
// [RULE3] Low-wattage bit 0: bulb cooling is timed through six successive steps.
// [RULE4] Cooling code 00 and 11 medium, 01 fast, 10 slow; medium starts 347 ms at low-wattage bit 0, 417 ms at bit 1.
// [RULE5] Fault flag pin goes low only after the fault outlasts the blanking time.
// [RULE6] Temperature, current, short or undervoltage fault turns output off after flag falls.
// [RULE7] Fail-safe open: watchdog runs from reset; on expiry outputs 0, 2 follow inputs.
// [RULE8] Low-wattage bit 0 uses the standard profile, slow 6.30 ms up to 104.6 ms.
// [RULE9] While on, steps advance in order, each its own duration and threshold.
package ocp_pkg;
	localparam int CLK_NS = 4;
	localparam int TICK_US = 10;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
	localparam int BLANK_NS = 5000;
	localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHUT_NS = 7000;
	localparam int SHUT_CYC = SHUT_NS / CLK_NS;
	localparam int WDOG_MS = 310;
	localparam int WDOG_TICKS = WDOG_MS * 1000 / TICK_US;
	localparam int OC_STEPS = 7;
	localparam int CB_STEPS = 6;
	localparam logic [1:0] OC_SPEED_RST = 2'h0;
	localparam logic [1:0] CB_SPEED_RST = 2'h0;
	typedef logic [16:0] dur_t;
	// Over-current steps [low-wattage bit][speed code][step], ms x 100
	localparam dur_t OC_TAB [2][4][OC_STEPS] = '{
		'{'{630, 232, 300, 412, 656, 1452, 10460},
		  '{157, 58, 75, 103, 164, 363, 2610},
		  '{315, 116, 150, 206, 328, 726, 5230},
		  '{1260, 460, 600, 820, 1310, 2900, 20920}},
		'{'{490, 160, 210, 290, 490, 1220, 8920},
		  '{124, 40, 52, 74, 112, 306, 2220},
		  '{250, 80, 100, 150, 250, 610, 4460},
		  '{980, 320, 420, 580, 980, 2440, 17840}}};
	// Cooling steps [low-wattage bit][0 medium, 1 fast, 2 slow][step], ms x 100
	localparam dur_t CB_TAB [2][3][CB_STEPS] = '{
		'{'{34700, 18100, 20000, 22600, 25900, 30200},
		  '{17300, 9000, 10000, 11300, 12900, 15100},
		  '{69400, 36200, 40000, 45200, 51800, 60400}},
		'{'{41700, 22400, 25500, 29800, 35900, 44900},
		  '{20900, 11200, 12700, 14500, 18000, 32400},
		  '{83400, 44800, 51000, 59600, 71700, 89800}}};
	typedef enum logic [2:0] {CH_IDLE, CH_INRUSH, CH_STEADY, CH_COOL, CH_TRIP} ch_state_t;
endpackage

// *** src/ocp_channel.sv ***
// Purpose: One switched output: inrush profile, cooling profile, fault timing
// Assumes: tick_in is a one-cycle pulse every time base period
// Notes: A trip holds the output off until the on command is withdrawn
`timescale 1ns/1ns
module ocp_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick_in,
	input wire logic on_in,
	input wire logic oc_above_in,
	input wire logic hard_fault_in,
	input wire logic [1:0] oc_speed_in,
	input wire logic [1:0] cb_speed_in,
	input wire logic low_watt_in,
	output logic drive_out,
	output logic fault_out,
	output logic cooling_out,
	output logic [2:0] step_out
);
	ocp_pkg::ch_state_t state_r;
	ocp_pkg::dur_t timer_r;
	logic [2:0] step_r;
	logic [11:0] blank_cnt_r;
	logic [11:0] shut_cnt_r;
	logic fault_r;
	logic drive_r;
	logic raw_fault;
	logic [1:0] cb_row;
	ocp_pkg::dur_t oc_first, oc_next, cb_first, cb_next;

	// Profile lookups; cooling codes 00 and 11 share the medium row
	always_comb begin
		cb_row = (cb_speed_in == 2'h3) ? 2'h0 : cb_speed_in; // see [RULE4]
		oc_first = ocp_pkg::OC_TAB[low_watt_in][oc_speed_in][0]; // see [RULE1] see [RULE2] see [RULE8]
		oc_next = ocp_pkg::OC_TAB[low_watt_in][oc_speed_in][(step_r == 3'h6) ? 3'h6 : step_r + 3'h1];
		cb_first = ocp_pkg::CB_TAB[low_watt_in][cb_row][0];
		cb_next = ocp_pkg::CB_TAB[low_watt_in][cb_row][(step_r >= 3'h5) ? 3'h5 : step_r + 3'h1];
	end

	// Any fault counts only while the output is driven
	assign raw_fault = drive_r && (oc_above_in || hard_fault_in);

	// Phase sequencing and step timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ocp_pkg::CH_IDLE;
			timer_r <= '0;
			step_r <= 3'h0;
		end else begin
			unique case (state_r)
				ocp_pkg::CH_IDLE, ocp_pkg::CH_COOL: begin
					if (on_in) begin
						state_r <= ocp_pkg::CH_INRUSH;
						step_r <= 3'h0;
						timer_r <= oc_first;
					end else if (state_r == ocp_pkg::CH_COOL && tick_in) begin
						if (timer_r > ocp_pkg::dur_t'(1)) begin
							timer_r <= timer_r - ocp_pkg::dur_t'(1);
						end else if (step_r == 3'(ocp_pkg::CB_STEPS - 1)) begin
							state_r <= ocp_pkg::CH_IDLE; // see [RULE3]
						end else begin
							step_r <= step_r + 3'h1;
							timer_r <= cb_next;
						end
					end
				end
				ocp_pkg::CH_INRUSH, ocp_pkg::CH_STEADY: begin
					if (shut_cnt_r == 12'(ocp_pkg::SHUT_CYC)) begin
						state_r <= ocp_pkg::CH_TRIP;
					end else if (!on_in) begin
						state_r <= ocp_pkg::CH_COOL;
						step_r <= 3'h0;
						timer_r <= cb_first;
					end else if (state_r == ocp_pkg::CH_INRUSH && tick_in) begin
						if (timer_r > ocp_pkg::dur_t'(1)) begin
							timer_r <= timer_r - ocp_pkg::dur_t'(1);
						end else if (step_r == 3'(ocp_pkg::OC_STEPS - 1)) begin
							state_r <= ocp_pkg::CH_STEADY;
						end else begin
							step_r <= step_r + 3'h1; // see [RULE9]
							timer_r <= oc_next;
						end
					end
				end
				ocp_pkg::CH_TRIP: begin
					if (!on_in) begin
						state_r <= ocp_pkg::CH_IDLE;
						step_r <= 3'h0;
					end
				end
				default: state_r <= ocp_pkg::CH_IDLE;
			endcase
		end
	end

	// Blanking: the fault must persist before it is reported
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blank_cnt_r <= '0;
			fault_r <= 1'b0;
		end else if (state_r == ocp_pkg::CH_TRIP && !on_in) begin
			blank_cnt_r <= '0;
			fault_r <= 1'b0;
		end else if (!fault_r) begin
			if (!raw_fault) begin
				blank_cnt_r <= '0;
			end else if (blank_cnt_r == 12'(ocp_pkg::BLANK_CYC)) begin
				fault_r <= 1'b1; // see [RULE5]
			end else begin
				blank_cnt_r <= blank_cnt_r + 12'h1;
			end
		end
	end

	// Shutdown delay counted from the flag falling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shut_cnt_r <= '0;
		end else if (!fault_r) begin
			shut_cnt_r <= '0;
		end else if (shut_cnt_r != 12'(ocp_pkg::SHUT_CYC)) begin
			shut_cnt_r <= shut_cnt_r + 12'h1; // see [RULE6]
		end
	end

	// Output drive follows the on phases
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_r <= 1'b0;
		end else begin
			drive_r <= on_in && shut_cnt_r != 12'(ocp_pkg::SHUT_CYC) &&
				(state_r == ocp_pkg::CH_INRUSH || state_r == ocp_pkg::CH_STEADY);
		end
	end

	assign drive_out = drive_r;
	assign fault_out = fault_r;
	assign cooling_out = state_r == ocp_pkg::CH_COOL;
	assign step_out = step_r;

	a_blank_len: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
		$rose(fault_r) |-> $past(blank_cnt_r) == 12'(ocp_pkg::BLANK_CYC) && $past(raw_fault))
		else $error("fault flagged before blanking time");
	a_shut_delay: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
		$fell(drive_r) && fault_r |-> shut_cnt_r == 12'(ocp_pkg::SHUT_CYC))
		else $error("output shut off at wrong delay");
	a_trip_off: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE6]
		state_r == ocp_pkg::CH_TRIP |=> !drive_r)
		else $error("tripped output still driven");
	a_step_order: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
		state_r == ocp_pkg::CH_INRUSH && $past(state_r) == ocp_pkg::CH_INRUSH && $changed(step_r)
		|-> step_r == $past(step_r) + 3'h1)
		else $error("inrush step skipped");
	a_cool_start: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE3]
		state_r == ocp_pkg::CH_STEADY && !on_in && shut_cnt_r == 12'h0
		|=> state_r == ocp_pkg::CH_COOL && step_r == 3'h0 && timer_r == $past(cb_first))
		else $error("cooling did not start");
	c_steady: cover property (@(posedge clk) disable iff (!rst_n) state_r == ocp_pkg::CH_STEADY);
	c_trip: cover property (@(posedge clk) disable iff (!rst_n) state_r == ocp_pkg::CH_TRIP);
	c_cool_done: cover property (@(posedge clk) disable iff (!rst_n)
		state_r == ocp_pkg::CH_COOL ##1 state_r == ocp_pkg::CH_IDLE);
endmodule

// *** src/ocp_timing.sv ***
// Purpose: Quad lamp switch timing: profiles, fault flag, watchdog fail-safe
// Assumes: All inputs synchronous to CLOCK_IN; speed fields held by the serial side
// Notes: Thresholds are analog; this block only names the active step per output
`timescale 1ns/1ns
module ocp_timing #(
	parameter int TICK_CYCLES = ocp_pkg::TICK_CYC,
	parameter int WDOG_TICKS = ocp_pkg::WDOG_TICKS
) (
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	// Settings from the serial side
	input wire logic [1:0] OVERCURRENT_SPEED_FIELD_IN,
	input wire logic [1:0] COOLING_SPEED_FIELD_IN,
	input wire logic LOW_WATTAGE_BULB_BIT_IN,
	input wire logic [3:0] HOST_ON_IN,
	input wire logic WDOG_KICK_IN,
	// Direct inputs and fail-safe select
	input wire logic [3:0] DIRECT_ON_IN,
	input wire logic FAILSAFE_SELECT_OPEN_IN,
	// Analog comparators and detectors
	input wire logic [3:0] OVERCURRENT_FAULT_IN,
	input wire logic [3:0] OVERTEMPERATURE_FAULT_IN,
	input wire logic [3:0] SHORT_CIRCUIT_FAULT_IN,
	input wire logic UNDERVOLTAGE_FAULT_IN,
	// Outputs
	output logic [3:0] SWITCHED_OUTPUT_OUT,
	output logic [3:0] CHANNEL_FAULT_OUT,
	output logic [3:0] COOLING_OUT,
	output logic [11:0] STEP_OUT,
	output logic FAULT_FLAG_PIN_N_OUT,
	output logic FAILSAFE_OUT
);
	logic [11:0] tick_cnt_r;
	logic tick_r;
	logic [16:0] wd_cnt_r;
	logic failsafe_r;
	logic flag_n_r;
	logic [3:0] cmd_on;
	logic [3:0] ch_fault;
	logic [12:0] flag_cnt_r;

	// Time base tick
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= tick_cnt_r == 12'(TICK_CYCLES - 1);
			tick_cnt_r <= (tick_cnt_r == 12'(TICK_CYCLES - 1)) ? 12'h0 : tick_cnt_r + 12'h1;
		end
	end

	// Watchdog starts at reset release; serial activity restarts it
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			wd_cnt_r <= '0;
			failsafe_r <= 1'b0;
		end else if (WDOG_KICK_IN || !FAILSAFE_SELECT_OPEN_IN) begin
			wd_cnt_r <= '0;
			failsafe_r <= 1'b0;
		end else if (wd_cnt_r == 17'(WDOG_TICKS)) begin
			failsafe_r <= 1'b1; // see [RULE7]
		end else if (tick_r) begin
			wd_cnt_r <= wd_cnt_r + 17'h1;
		end
	end

	// In fail-safe only outputs 0 and 2 run, from their direct inputs
	assign cmd_on = failsafe_r ? (DIRECT_ON_IN & 4'h5) : HOST_ON_IN; // see [RULE7]

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			ocp_channel u_ch (
				.clk(CLOCK_IN),
				.rst_n(NRST_IN),
				.tick_in(tick_r),
				.on_in(cmd_on[g]),
				.oc_above_in(OVERCURRENT_FAULT_IN[g]),
				.hard_fault_in(OVERTEMPERATURE_FAULT_IN[g] || SHORT_CIRCUIT_FAULT_IN[g] ||
					UNDERVOLTAGE_FAULT_IN),
				.oc_speed_in(OVERCURRENT_SPEED_FIELD_IN),
				.cb_speed_in(COOLING_SPEED_FIELD_IN),
				.low_watt_in(LOW_WATTAGE_BULB_BIT_IN),
				.drive_out(SWITCHED_OUTPUT_OUT[g]),
				.fault_out(ch_fault[g]),
				.cooling_out(COOLING_OUT[g]),
				.step_out(STEP_OUT[3*g +: 3])
			);
		end
	endgenerate

	// Shared active-low fault flag pin
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			flag_n_r <= 1'b1;
		end else begin
			flag_n_r <= ~|ch_fault; // see [RULE5]
		end
	end

	// Cycles a faulty output stays driven after the flag fell, for the shutoff check
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			flag_cnt_r <= '0;
		end else if (!flag_n_r && |(SWITCHED_OUTPUT_OUT & ch_fault)) begin
			flag_cnt_r <= flag_cnt_r + 13'h1; // see [RULE6]
		end else begin
			flag_cnt_r <= '0;
		end
	end

	assign FAULT_FLAG_PIN_N_OUT = flag_n_r;
	assign FAILSAFE_OUT = failsafe_r;
	assign CHANNEL_FAULT_OUT = ch_fault;

	a_wdog_expire: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // see [RULE7]
		$rose(failsafe_r) |-> wd_cnt_r == 17'(WDOG_TICKS) && $past(FAILSAFE_SELECT_OPEN_IN))
		else $error("watchdog expired at wrong count");
	a_failsafe_odd_off: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // see [RULE7]
		failsafe_r && $past(failsafe_r, 3) && $past(failsafe_r, 2) && $past(failsafe_r)
		|-> !SWITCHED_OUTPUT_OUT[1] && !SWITCHED_OUTPUT_OUT[3])
		else $error("outputs 1 or 3 driven in fail-safe");
	a_flag_shutoff: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // see [RULE6]
		flag_cnt_r <= 13'(ocp_pkg::SHUT_CYC + 2))
		else $error("faulty output not shut off after flag fell");
	c_failsafe: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(failsafe_r));
	c_flag: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) !FAULT_FLAG_PIN_N_OUT);
endmodule

// *** verif/host_model.sv ***
// Purpose: Host side model: speed settings, on commands, watchdog kicks
// Assumes: Changes its outputs on the falling clock edge
// Notes: Kicks come every 32 cycles while kick_en is set
`timescale 1ns/1ns
module host_model (
	input wire logic clk,
	output logic [1:0] oc_speed,
	output logic [1:0] cb_speed,
	output logic low_watt,
	output logic [3:0] on_cmd,
	output logic kick
);
	logic kick_en = 1'b0;
	int gap = 0;
	// Settings start at slow over-current speed and medium cooling speed, everything off
	initial begin
		oc_speed = 2'h0;
		cb_speed = 2'h0;
		low_watt = 1'b0;
		on_cmd = 4'h0;
		kick = 1'b0;
	end
	// Periodic serial traffic, one-cycle pulse
	always @(negedge clk) begin
		gap <= (gap == 31) ? 0 : gap + 1;
		kick <= kick_en && gap == 31;
	end
	task automatic set_cfg(input logic [1:0] o, input logic [1:0] c, input logic b);
		@(negedge clk);
		oc_speed = o;
		cb_speed = c;
		low_watt = b;
	endtask
	task automatic set_on(input int g, input logic v);
		@(negedge clk);
		on_cmd[g] = v;
	endtask
endmodule

// *** verif/tb_ocp_timing.sv ***
// Purpose: Self-checking bench for the lamp switch timing block
// Assumes: Time base shortened to 2 cycles, watchdog to 20 ticks
// Notes: Cooling on output 0 and fault tests on output 1 run side by side
`timescale 1ns/1ns
module tb_ocp_timing;
	localparam int TK = 2;
	localparam int WD = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fs_open = 1'b1;
	logic [3:0] dir_on = 4'h0;
	logic [3:0] f_oc = 4'h0;
	logic [3:0] f_ot = 4'h0;
	logic [3:0] f_sc = 4'h0;
	logic f_uv = 1'b0;
	logic [1:0] ocs;
	logic [1:0] cbs;
	logic lw;
	logic kick;
	logic flag_n;
	logic fsafe;
	logic [3:0] hon;
	logic [3:0] sw;
	logic [3:0] chf;
	logic [3:0] cool;
	logic [11:0] step;
	int total_checks = 0;
	int n_mismatch = 0;
	int n;
	// Clock, 4 ns period
	initial begin
		forever #2 clk = ~clk;
	end
	host_model host (.clk(clk), .oc_speed(ocs), .cb_speed(cbs), .low_watt(lw),
		.on_cmd(hon), .kick(kick));
	ocp_timing #(.TICK_CYCLES(TK), .WDOG_TICKS(WD)) dut (.CLOCK_IN(clk), .NRST_IN(rst_n),
		.OVERCURRENT_SPEED_FIELD_IN(ocs), .COOLING_SPEED_FIELD_IN(cbs),
		.LOW_WATTAGE_BULB_BIT_IN(lw), .HOST_ON_IN(hon), .WDOG_KICK_IN(kick),
		.DIRECT_ON_IN(dir_on), .FAILSAFE_SELECT_OPEN_IN(fs_open),
		.OVERCURRENT_FAULT_IN(f_oc), .OVERTEMPERATURE_FAULT_IN(f_ot),
		.SHORT_CIRCUIT_FAULT_IN(f_sc), .UNDERVOLTAGE_FAULT_IN(f_uv),
		.SWITCHED_OUTPUT_OUT(sw), .CHANNEL_FAULT_OUT(chf), .COOLING_OUT(cool),
		.STEP_OUT(step), .FAULT_FLAG_PIN_N_OUT(flag_n), .FAILSAFE_OUT(fsafe));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Counts inside the tolerance map onto the expected figure
	function automatic logic [31:0] near(input int c, input int e, input int tol);
		return (c >= e - tol && c <= e + tol) ? e : c;
	endfunction
	// Cycles that output g stays in its present step and phase
	task automatic run_len(input int g, input logic cl, output int c);
		logic [2:0] s0;
		c = 0;
		s0 = step[3*g +: 3];
		while (step[3*g +: 3] === s0 && cool[g] === cl && c < 80000) begin
			@(negedge clk);
			c++;
		end
	endtask
	// Output 0 on, then ns inrush steps timed
	task automatic walk(input logic b, input logic [1:0] code, input int ns);
		int c;
		int e;
		host.set_cfg(code, 2'h1, b);
		host.set_on(0, 1'b1);
		repeat (2) @(negedge clk);
		check(cool[0], 1'b0);
		for (int s = 0; s < ns; s++) begin
			check(step[2:0], s);
			e = ocp_pkg::OC_TAB[b][code][s] * TK;
			if (s < ocp_pkg::OC_STEPS - 1) begin
				run_len(0, 1'b0, c);
			end else begin
				// Last step ends in the steady phase, which keeps step 6 shown
				repeat (e) @(negedge clk);
				c = (step[2:0] === 3'h6 && cool[0] === 1'b0) ? e : 0;
			end
			check(near(c, e, TK + 3), e);
		end
		check(sw[0], 1'b1);
	endtask
	task automatic setf(input int k, input logic v);
		case (k)
			0: f_ot[1] = v;
			1: f_oc[1] = v;
			2: f_sc[1] = v;
			default: f_uv = v;
		endcase
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Cuts a hang short
	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		check({sw, chf, cool, step, fsafe, flag_n}, 32'h1);
		rst_n = 1'b1;
		n = 0;
		while (fsafe !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		check(near(n, WD * TK, TK + 3), WD * TK);
		dir_on = 4'h5;
		host.set_on(1, 1'b1);
		host.set_on(3, 1'b1);
		repeat (4) @(negedge clk);
		check(sw, 4'h5);
		dir_on = 4'h1;
		repeat (3) @(negedge clk);
		check(sw, 4'h1);
		host.kick_en = 1'b1;
		repeat (40) @(negedge clk);
		check({fsafe, sw}, 5'h0A);
		dir_on = 4'h0;
		host.set_on(1, 1'b0);
		host.set_on(3, 1'b0);
		for (int k = 0; k < 4; k++) begin
			walk(1'b1, k[1:0], 1);
			host.set_on(0, 1'b0);
		end
		walk(1'b0, 2'h1, 7);
		fork
			begin
				int c;
				host.set_on(0, 1'b0);
				repeat (2) @(negedge clk);
				check({sw[0], cool[0], step[2:0]}, 5'h08);
				run_len(0, 1'b1, c);
				check(near(c, ocp_pkg::CB_TAB[0][1][0] * TK, TK + 3),
					ocp_pkg::CB_TAB[0][1][0] * TK);
				host.set_on(0, 1'b1);
				repeat (2) @(negedge clk);
				check({cool[0], step[2:0]}, 4'h0);
			end
			begin
				int m;
				for (int k = 0; k < 4; k++) begin
					host.set_on(1, 1'b1);
					repeat (4) @(negedge clk);
					setf(k, 1'b1);
					repeat (1000) @(negedge clk);
					setf(k, 1'b0);
					@(negedge clk);
					check({chf[1], flag_n}, 2'h1);
					setf(k, 1'b1);
					m = 0;
					while (chf[1] !== 1'b1 && m < 3000) begin
						@(negedge clk);
						m++;
					end
					check(near(m, ocp_pkg::BLANK_CYC + 1, 3), ocp_pkg::BLANK_CYC + 1);
					@(negedge clk);
					check(flag_n, 1'b0);
					m = 0;
					while (sw[1] !== 1'b0 && m < 4000) begin
						@(negedge clk);
						m++;
					end
					check(near(m, ocp_pkg::SHUT_CYC, 4), ocp_pkg::SHUT_CYC);
					setf(k, 1'b0);
					repeat (3) @(negedge clk);
					check(sw[1], 1'b0);
					host.set_on(1, 1'b0);
					repeat (3) @(negedge clk);
					check({chf[1], flag_n}, 2'h1);
				end
			end
		join
		tally_and_finish();
	end
endmodule
